// ==== hw/ebpwm_map.vh ====
// Constants for the enhanced bridge modulator: field codes and reset values.
// Assumes inclusion by bare name from the hw/ design files.
`ifndef EBPWM_MAP_VH
`define EBPWM_MAP_VH

// ****************************************
// Output steering mode codes
// ****************************************
`define EBPWM_STEER_SINGLE 2'h0
`define EBPWM_STEER_FWD 2'h1
`define EBPWM_STEER_HALF 2'h2
`define EBPWM_STEER_REV 2'h3

// ****************************************
// Modulator mode select field
// ****************************************
// Upper two bits equal to 2'b11 select modulation; low two pick polarity.
`define EBPWM_MODE_PWM 2'h3
`define EBPWM_MODE_HI 3
`define EBPWM_MODE_LO 2
`define EBPWM_POL_AC 0
`define EBPWM_POL_BD 1

// ****************************************
// Prescale select codes and reset values
// ****************************************
`define EBPWM_PRE_1 2'h0
`define EBPWM_PRE_4 2'h1
`define EBPWM_PERIOD_RST 8'hFF
`define EBPWM_COUNT_RST 8'h00
`define EBPWM_DUTY_RST 10'h000

`endif

// ==== hw/ebpwm_prescale.v ====
// Prescaler of the period timer: yields the two low bits of the 10-bit count.
// Assumes one clock, an active-low asynchronous reset and a clock enable.
`timescale 1ns/1ps
`default_nettype none
`include "ebpwm_map.vh"

module ebpwm_prescale (
  input wire clk,
  input wire rst_n,
  input wire ce,
  input wire run,
  input wire clear,
  input wire [1:0] sel,
  output reg [1:0] sub_bits,
  output wire tick
);

  // ****************************************
  // Prescale counter
  // ****************************************
  reg [3:0] pre_ff;
  reg [3:0] nxt_pre;
  reg [3:0] pre_max;

  // Terminal value per prescale code; codes above divide by sixteen.
  always @* begin
    case (sel)
      `EBPWM_PRE_1: pre_max = 4'h0;
      `EBPWM_PRE_4: pre_max = 4'h3;
      default: pre_max = 4'hF;
    endcase
  end

  assign tick = run && (pre_ff == pre_max);

  // Clear wins over counting so a new period always starts aligned.
  always @* begin
    if (clear)
      nxt_pre = 4'h0;
    else if (tick)
      nxt_pre = 4'h0;
    else if (run)
      nxt_pre = pre_ff + 4'h1;
    else
      nxt_pre = pre_ff;
  end

  // The count freezes while the enable is low, which is how sleep holds it.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pre_ff <= 4'h0;
    end else if (ce) begin
      pre_ff <= nxt_pre;
    end
  end

  // Two fractional bits of the 10-bit compare, scaled by prescale.
  always @* begin
    case (sel)
      `EBPWM_PRE_1: sub_bits = 2'h0;
      `EBPWM_PRE_4: sub_bits = pre_ff[1:0];
      default: sub_bits = pre_ff[3:2];
    endcase
  end

endmodule // ebpwm_prescale
`default_nettype wire

// ==== hw/ebpwm_top.v ====
// Enhanced bridge modulator: 8-bit period timer, 10-bit duty, four outputs.
// Assumes configuration comes from plain ports driven on CORE_CLK; SLEEP and
// CE are synchronous; pin direction bits are kept by software outside.
`timescale 1ns/1ps
`default_nettype none
`include "ebpwm_map.vh"

// Function
// - Sleep freezes timer and modulator state.
// - Primary pin holds its level in sleep.
// - Timer resumes from its held value.
// - All timing derives from system clock.
// - Reset makes pins inputs, registers reset.
// - Up to four outputs, ten-bit duty.
// - Steer 00 single A; 10 half A,B.
// - Steer 01 forward, 11 reverse, four pins.
// - Mode select bits set output polarity.
// - First pulse waits for new period.
// - Zero control releases pins; unused pins free.
// - Forward: A active, D modulated, B,C inactive.
// - Reverse: C active, B modulated, A,D inactive.
module ebpwm_top (
  input wire CORE_CLK,
  input wire NRST,
  input wire CE,
  input wire SLEEP,
  input wire PERIOD_TIMER_ON,
  input wire [1:0] TIMER_PRESCALE_SELECT,
  input wire [7:0] PERIOD_LIMIT_REG,
  input wire [1:0] OUTPUT_STEER_MODE,
  input wire [1:0] DUTY_LOW_BITS,
  input wire [3:0] MODULATOR_MODE_SELECT,
  input wire [7:0] DUTY_HIGH_BYTE,
  input wire [3:0] PIN_DIRECTION,
  input wire FLAG_CLEAR,
  output reg PERIOD_TIMER_FLAG,
  output wire [7:0] PERIOD_TIMER_COUNT,
  output reg BRIDGE_OUT_A,
  output reg BRIDGE_OUT_B,
  output reg BRIDGE_OUT_C,
  output reg BRIDGE_OUT_D,
  output reg [3:0] BRIDGE_OE
);

  // ****************************************
  // Control decode
  // ****************************************
  wire run_en;
  wire pwm_mode;
  wire [7:0] ctrl_word;
  wire match;
  wire tick;
  wire [1:0] sub_bits;
  wire [9:0] count10;

  // Sleep stops every register by withholding the enable.
  // CE and SLEEP come from logic on this clock, so they need no synchroniser.
  assign run_en = CE && !SLEEP;
  assign pwm_mode = (MODULATOR_MODE_SELECT[`EBPWM_MODE_HI:`EBPWM_MODE_LO]
    == `EBPWM_MODE_PWM);
  assign ctrl_word = {OUTPUT_STEER_MODE, DUTY_LOW_BITS,
    MODULATOR_MODE_SELECT};

  // ****************************************
  // Period timer
  // ****************************************
  reg [7:0] tmr_ff;
  reg [7:0] nxt_tmr;
  reg [9:0] duty_ff;
  reg armed_ff;
  reg pwm_ff;

  ebpwm_prescale u_pre (
    .clk(CORE_CLK),
    .rst_n(NRST),
    .ce(run_en),
    .run(PERIOD_TIMER_ON),
    .clear(match),
    .sub_bits(sub_bits),
    .sel(TIMER_PRESCALE_SELECT),
    .tick(tick)
  );

  // Match is taken on the tick so each timer value lasts a full prescale.
  assign match = tick && (tmr_ff == PERIOD_LIMIT_REG);
  // At divide-by-one the two low bits stay zero, so only duty values that
  // are multiples of four resolve; any other value never matches and the
  // pulse then fills the whole period.
  assign count10 = {tmr_ff, sub_bits};
  assign PERIOD_TIMER_COUNT = tmr_ff;

  always @* begin
    if (match)
      nxt_tmr = `EBPWM_COUNT_RST;
    else if (tick)
      nxt_tmr = tmr_ff + 8'h01;
    else
      nxt_tmr = tmr_ff;
  end

  // Timer and duty latch; both hold their value across sleep.
  always @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      tmr_ff <= `EBPWM_COUNT_RST;
      duty_ff <= `EBPWM_DUTY_RST;
    end else if (run_en) begin
      tmr_ff <= nxt_tmr;
      if (match)
        duty_ff <= {DUTY_HIGH_BYTE, DUTY_LOW_BITS};
    end
  end

  // Flag: a match in the clearing cycle keeps the flag set.
  always @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      PERIOD_TIMER_FLAG <= 1'b0;
    end else if (run_en) begin
      if (match)
        PERIOD_TIMER_FLAG <= 1'b1;
      else if (FLAG_CLEAR)
        PERIOD_TIMER_FLAG <= 1'b0;
    end
  end

  // ****************************************
  // Modulated waveform
  // ****************************************
  // Armed only after a period boundary, so no partial first pulse appears.
  // The clear is registered, so a pulse lasts one clock cycle past the start of
  // the duty value; a duty of zero still gives one cycle, traded for a simple compare.
  always @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      armed_ff <= 1'b0;
      pwm_ff <= 1'b0;
    end else if (run_en) begin
      if (!pwm_mode) begin
        armed_ff <= 1'b0;
        pwm_ff <= 1'b0;
      end else if (match) begin
        armed_ff <= 1'b1;
        pwm_ff <= 1'b1;
      end else if (tick && count10 == duty_ff) begin
        pwm_ff <= 1'b0;
      end else if (!tick && count10 == duty_ff) begin
        pwm_ff <= 1'b0;
      end
    end
  end

  // ****************************************
  // Steering, polarity and pin release
  // ****************************************
  reg [3:0] raw;
  reg [3:0] used;
  wire [3:0] pol_low;
  wire mod_on;

  assign mod_on = pwm_ff && armed_ff;

  // Raw active-high level per pin A..D and which pins the mode claims.
  always @* begin
    case (OUTPUT_STEER_MODE)
      `EBPWM_STEER_SINGLE: begin
        raw = {3'h0, mod_on};
        used = 4'h1;
      end
      `EBPWM_STEER_HALF: begin
        raw = {2'h0, !mod_on, mod_on};
        used = 4'h3;
      end
      `EBPWM_STEER_FWD: begin
        raw = {mod_on, 1'b0, 1'b0, armed_ff};
        used = 4'hF;
      end
      `EBPWM_STEER_REV: begin
        raw = {1'b0, armed_ff, mod_on, 1'b0};
        used = 4'hF;
      end
      default: begin
        raw = 4'h0;
        used = 4'h0;
      end
    endcase
  end

  // Polarity per pin: A and C follow bit 0, B and D follow bit 1. A set bit
  // makes that pin active low, so its inactive level is high.
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_pol
      if (gi % 2 == 0) begin : g_ac
        assign pol_low[gi] = MODULATOR_MODE_SELECT[`EBPWM_POL_AC];
      end else begin : g_bd
        assign pol_low[gi] = MODULATOR_MODE_SELECT[`EBPWM_POL_BD];
      end
    end
  endgenerate

  // Registered pins; in sleep the enable is off so levels simply hold.
  always @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      {BRIDGE_OUT_D, BRIDGE_OUT_C, BRIDGE_OUT_B, BRIDGE_OUT_A} <= 4'h0;
      BRIDGE_OE <= 4'h0;
    end else if (run_en) begin
      {BRIDGE_OUT_D, BRIDGE_OUT_C, BRIDGE_OUT_B, BRIDGE_OUT_A} <=
        raw ^ pol_low;
      // Zero control or non-modulating mode gives every pin back.
      if (ctrl_word == 8'h00 || !pwm_mode)
        BRIDGE_OE <= 4'h0;
      else
        BRIDGE_OE <= used & ~PIN_DIRECTION;
    end
  end

endmodule // ebpwm_top
`default_nettype wire

// ==== verif/ebpwm_properties.sv ====
// Checker of the bridge modulator, bound to ebpwm_top.
// Assumes the map header is on the include path.
`timescale 1ns/1ps
`default_nettype none
`include "ebpwm_map.vh"
module ebpwm_properties (
  input wire CORE_CLK,
  input wire NRST,
  input wire CE,
  input wire SLEEP,
  input wire PERIOD_TIMER_ON,
  input wire [1:0] TIMER_PRESCALE_SELECT,
  input wire [7:0] PERIOD_LIMIT_REG,
  input wire [1:0] OUTPUT_STEER_MODE,
  input wire [3:0] MODULATOR_MODE_SELECT,
  input wire [3:0] PIN_DIRECTION,
  input wire FLAG_CLEAR,
  input wire PERIOD_TIMER_FLAG,
  input wire [7:0] PERIOD_TIMER_COUNT,
  input wire BRIDGE_OUT_A,
  input wire BRIDGE_OUT_B,
  input wire BRIDGE_OUT_C,
  input wire BRIDGE_OUT_D,
  input wire [3:0] BRIDGE_OE
);
  // One clock domain, so clock and reset are given once.
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!NRST);
  // The timer steps every cycle only at divide-by-one.
  wire run = CE && !SLEEP && PERIOD_TIMER_ON && TIMER_PRESCALE_SELECT == 2'h0;
  wire hit = PERIOD_TIMER_COUNT == PERIOD_LIMIT_REG;
  wire [13:0] st = {PERIOD_TIMER_COUNT, PERIOD_TIMER_FLAG, BRIDGE_OUT_A,
    BRIDGE_OUT_B, BRIDGE_OUT_C, BRIDGE_OUT_D, BRIDGE_OE[0]};
  wire fwd = OUTPUT_STEER_MODE == `EBPWM_STEER_FWD;
  wire rev = OUTPUT_STEER_MODE == `EBPWM_STEER_REV;
  wire on = BRIDGE_OE == 4'hF && MODULATOR_MODE_SELECT == 4'hC;
  // Shadow of the arming: pins stay inactive until a period match.
  reg seen_ff;
  always @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST)
      seen_ff <= 1'b0;
    else if (CE && !SLEEP && MODULATOR_MODE_SELECT[3:2] != 2'h3)
      seen_ff <= 1'b0;
    else if (run && hit)
      seen_ff <= 1'b1;
  end
  a_reset_idle: assert property ($rose(NRST) |-> BRIDGE_OE == 4'h0)
    else $error("pins driven after reset");
  a_hold_frozen: assert property ((SLEEP || !CE) |=> $stable(st))
    else $error("state moved while frozen");
  a_count_step: assert property (run && !hit |=>
    PERIOD_TIMER_COUNT == $past(PERIOD_TIMER_COUNT) + 8'h01)
    else $error("timer did not step");
  a_period_match: assert property (run && hit |=>
    PERIOD_TIMER_COUNT == 8'h00 && PERIOD_TIMER_FLAG)
    else $error("period match not handled");
  a_flag_sticky: assert property (PERIOD_TIMER_FLAG && !FLAG_CLEAR |=>
    PERIOD_TIMER_FLAG) else $error("flag lost");
  a_oe_release: assert property (MODULATOR_MODE_SELECT[3:2] != 2'h3 &&
    CE && !SLEEP |=> BRIDGE_OE == 4'h0) else $error("pins not released");
  a_oe_direction: assert property (!(|(BRIDGE_OE & $past(PIN_DIRECTION))))
    else $error("input pin driven");
  a_fwd_steer: assert property (on && fwd && $past(fwd, 2) &&
    $past(seen_ff) |-> BRIDGE_OUT_A && !BRIDGE_OUT_B && !BRIDGE_OUT_C)
    else $error("forward steering wrong");
  a_rev_steer: assert property (on && rev && $past(rev, 2) &&
    $past(seen_ff) |-> BRIDGE_OUT_C && !BRIDGE_OUT_A && !BRIDGE_OUT_D)
    else $error("reverse steering wrong");
  c_match: cover property (run && hit);
  c_wake: cover property (SLEEP ##1 !SLEEP);
  c_rev: cover property (on && rev);
endmodule // ebpwm_properties
bind ebpwm_top ebpwm_properties u_props (.*);
`default_nettype wire

// ==== verif/ebpwm_bridge_model.sv ====
// Model of the external bridge switches: A,B left leg, C,D right leg.
// Assumes a high pin level turns its switch on.
`timescale 1ns/1ps
`default_nettype none
module ebpwm_bridge_model (
  input wire [3:0] pin,
  input wire [3:0] oe,
  output wire leg_short
);
  // A released gate is pulled off, so only a driven high pin conducts.
  wire [3:0] on = pin & oe;
  // Both switches of one leg on would short the supply.
  assign leg_short = (on[0] && on[1]) || (on[2] && on[3]);
endmodule // ebpwm_bridge_model
`default_nettype wire

// ==== verif/enhanced_bridge_pwm_tb.sv ====
// Self-checking bench of the bridge modulator, divide-by-one and divide-by-four prescale.
// Assumes the map header is on the include path.
`timescale 1ns/1ps
`default_nettype none
`include "ebpwm_map.vh"
module enhanced_bridge_pwm_tb;
  logic CORE_CLK = 1'b0, NRST = 1'b0, CE = 1'b1, SLEEP = 1'b0;
  logic PERIOD_TIMER_ON = 1'b0, FLAG_CLEAR = 1'b0, PERIOD_TIMER_FLAG;
  logic BRIDGE_OUT_A, BRIDGE_OUT_B, BRIDGE_OUT_C, BRIDGE_OUT_D, leg_short;
  logic [1:0] TIMER_PRESCALE_SELECT = 2'h0, OUTPUT_STEER_MODE = 2'h0;
  logic [1:0] DUTY_LOW_BITS = 2'h0;
  logic [3:0] MODULATOR_MODE_SELECT = 4'h0, PIN_DIRECTION = 4'hF, BRIDGE_OE;
  logic [7:0] PERIOD_LIMIT_REG = 8'h03, DUTY_HIGH_BYTE = 8'h02;
  logic [7:0] PERIOD_TIMER_COUNT, c;
  logic [3:0] p;
  integer n_fail = 0, checks = 0, hi, i, span = 1;
  wire [3:0] pins = {BRIDGE_OUT_D, BRIDGE_OUT_C, BRIDGE_OUT_B, BRIDGE_OUT_A};
  ebpwm_top u_dut (.*);
  ebpwm_bridge_model u_bridge (.pin(pins), .oe(BRIDGE_OE),
    .leg_short(leg_short));
  // Core clock at 20 MHz.
  always #25 CORE_CLK = ~CORE_CLK;
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks = checks + 1;
    if (got !== exp) begin
      n_fail = n_fail + 1;
      $display("wrong value at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task cyc(input integer n);
    repeat (n) @(negedge CORE_CLK);
  endtask
  // Any window of one steady period (span is the prescale) holds one pulse.
  task meas(input integer sel, output integer h);
    integer k;
    h = 0;
    for (k = 0; k < (PERIOD_LIMIT_REG + 1) * span; k = k + 1) begin
      cyc(1);
      h = h + pins[sel];
      chk(leg_short, 1'b0);
    end
  endtask
  task give_verdict;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Watchdog: the tests need some 190 cycles.
  initial begin
    #100000;
    n_fail = n_fail + 1;
    give_verdict;
  end
  initial begin
    cyc(6);
    chk(BRIDGE_OE, 4'h0);
    NRST = 1'b1;
    MODULATOR_MODE_SELECT = 4'hC;
    FLAG_CLEAR = 1'b1;
    cyc(1);
    FLAG_CLEAR = 1'b0;
    PERIOD_TIMER_ON = 1'b1;
    for (i = 0; i < 20 && PERIOD_TIMER_FLAG !== 1'b1; i = i + 1) cyc(1);
    chk(PERIOD_TIMER_FLAG, 1'b1);
    PIN_DIRECTION = 4'hE;
    cyc(2);
    chk(BRIDGE_OE, 4'h1);
    // Duty 0, 4, 8 gives 1, 2, 3 active cycles of four.
    for (i = 0; i < 3; i = i + 1) begin
      {DUTY_HIGH_BYTE, DUTY_LOW_BITS} = {i[7:0], 2'h0};
      cyc(10);
      meas(0, hi);
      chk(hi, i + 1);
    end
    MODULATOR_MODE_SELECT = 4'hD;
    cyc(10);
    meas(0, hi);
    chk(hi, 1);
    MODULATOR_MODE_SELECT = 4'hC;
    OUTPUT_STEER_MODE = `EBPWM_STEER_HALF;
    PIN_DIRECTION = 4'hC;
    cyc(10);
    chk(BRIDGE_OE, 4'h3);
    meas(1, hi);
    chk(hi, 1);
    OUTPUT_STEER_MODE = `EBPWM_STEER_FWD;
    PIN_DIRECTION = 4'h0;
    cyc(10);
    chk(pins & 4'h7, 4'h1);
    meas(3, hi);
    chk(hi, 3);
    OUTPUT_STEER_MODE = `EBPWM_STEER_REV;
    cyc(10);
    chk(pins & 4'hD, 4'h4);
    meas(1, hi);
    chk(hi, 3);
    SLEEP = 1'b1;
    cyc(1);
    c = PERIOD_TIMER_COUNT;
    p = pins;
    cyc(5);
    chk(PERIOD_TIMER_COUNT, c);
    chk(pins, p);
    SLEEP = 1'b0;
    cyc(1);
    chk(PERIOD_TIMER_COUNT, (c == PERIOD_LIMIT_REG) ? 8'h00 : c + 8'h01);
    CE = 1'b0;
    cyc(1);
    c = PERIOD_TIMER_COUNT;
    p = pins;
    cyc(3);
    chk(PERIOD_TIMER_COUNT, c);
    chk(pins, p);
    CE = 1'b1;
    MODULATOR_MODE_SELECT = 4'h0;
    OUTPUT_STEER_MODE = `EBPWM_STEER_SINGLE;
    cyc(2);
    chk(BRIDGE_OE, 4'h0);
    for (i = 0; i < 9 && PERIOD_TIMER_COUNT !== 8'h01; i = i + 1) cyc(1);
    MODULATOR_MODE_SELECT = 4'hC;
    OUTPUT_STEER_MODE = `EBPWM_STEER_REV;
    cyc(1);
    chk(pins, 4'h0);
    cyc(5);
    chk(BRIDGE_OE, 4'hF);
    chk(pins & 4'hD, 4'h4);
    // Divide by four: duty 6 gives seven active cycles of sixteen.
    TIMER_PRESCALE_SELECT = `EBPWM_PRE_4;
    {DUTY_HIGH_BYTE, DUTY_LOW_BITS} = {8'h01, 2'h2};
    span = 4;
    cyc(40);
    meas(1, hi);
    chk(hi, 7);
    NRST = 1'b0;
    cyc(1);
    chk({BRIDGE_OE, PERIOD_TIMER_FLAG}, 5'h00);
    give_verdict;
  end
endmodule // enhanced_bridge_pwm_tb
`default_nettype wire
